//--- ppic_top.v
// Port pin interrupt control: control register, pending flags, masks.
// Assumes synchronous pin inputs and an Avalon-MM master.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`include "ppic_defs.vh"

module ppic_top (
  input  wire       i_clk,            // System clock, 25 MHz
  input  wire       i_rst_n,          // Async reset, active low
  input  wire [7:0] i_avs_address,    // Byte address
  input  wire       i_avs_read,       // Read strobe
  input  wire       i_avs_write,      // Write strobe
  input  wire [7:0] i_avs_writedata,  // Write data
  output reg  [7:0] o_avs_readdata,   // Read data
  output reg        o_avs_waitrequest,// Stall until answer
  input  wire [7:0] i_port0,          // Port 0 pins
  input  wire [7:0] i_port1,          // Port 1 pins
  input  wire [4:0] i_port2,          // Port 2 pins
  input  wire       i_resume,         // Bus resume event level
  output reg        o_port0_irq,      // Port 0 request level
  output reg        o_port1_irq,      // Port 1 request level
  output reg        o_port2_irq       // Port 2 request level
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0] port_interrupt_control;
  reg  [7:0] port1_pin_irq_mask;
  reg  [7:0] port0_pending_flags;
  reg  [7:0] port1_pending_flags;
  reg  [4:0] port2_pending_flags;
  reg        done;

  wire       port2_group_irq_enable;
  wire       port0_upper_irq_enable;
  wire       port0_lower_irq_enable;
  wire       port0_edge_select;
  wire       port1_edge_select;
  wire       port2_edge_select;
  wire [7:0] edge0;
  wire [7:0] edge1;
  wire [4:0] edge2;
  wire [7:0] hit0;
  wire [7:0] hit1;
  wire [4:0] hit2;
  wire       req;
  wire       wr;
  wire       resume_edge;
  reg        resume_prev;

  assign port2_group_irq_enable = port_interrupt_control[`PPIC_CTRL_P2_EN];
  assign port0_upper_irq_enable = port_interrupt_control[`PPIC_CTRL_P0H_EN];
  assign port0_lower_irq_enable = port_interrupt_control[`PPIC_CTRL_P0L_EN];
  assign port0_edge_select = port_interrupt_control[`PPIC_CTRL_P0_EDGE];
  assign port1_edge_select = port_interrupt_control[`PPIC_CTRL_P1_EDGE];
  assign port2_edge_select = port_interrupt_control[`PPIC_CTRL_P2_EDGE];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Port 0 edge choice
  ppic_edge #(.WIDTH(8)) u_edge0 (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pins  (i_port0),
    .i_fall  (port0_edge_select),
    .o_edge  (edge0)
  );

  ppic_edge #(.WIDTH(8)) u_edge1 (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pins  (i_port1),
    .i_fall  (port1_edge_select),
    .o_edge  (edge1)
  );

  ppic_edge #(.WIDTH(5)) u_edge2 (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pins  (i_port2),
    .i_fall  (port2_edge_select),
    .o_edge  (edge2)
  );

  // Resume detected on rising edge only
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resume_prev <= 1'b0;
    end else begin
      resume_prev <= i_resume;
    end
  end
  assign resume_edge = i_resume & ~resume_prev;

  // ----------------------------------------------------------------
  // Group gating
  // ----------------------------------------------------------------
  // Upper nibble gate
  assign hit0[7] = (edge0[7] | resume_edge) & port0_upper_irq_enable;
  assign hit0[6:4] = edge0[6:4] & {3{port0_upper_irq_enable}};
  assign hit0[3:0] = edge0[3:0] & {4{port0_lower_irq_enable}};
  assign hit1 = edge1 & port1_pin_irq_mask;
  assign hit2 = edge2 & {5{port2_group_irq_enable}};

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait cycle per access
  // ----------------------------------------------------------------
  assign req = (i_avs_read | i_avs_write) & ~done;
  assign wr  = i_avs_write & ~done;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done              <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 8'h00;
    end else begin
      done              <= req;
      o_avs_waitrequest <= ~req;
      if (req && i_avs_read) begin
        case (i_avs_address)
          `PPIC_OFS_P0_FLAGS: o_avs_readdata <= port0_pending_flags;
          `PPIC_OFS_P1_FLAGS: o_avs_readdata <= port1_pending_flags;
          `PPIC_OFS_P2_FLAGS: o_avs_readdata <= {3'b000, port2_pending_flags};
          `PPIC_OFS_CTRL:     o_avs_readdata <= port_interrupt_control;
          `PPIC_OFS_P1_MASK:  o_avs_readdata <= port1_pin_irq_mask;
          default:            o_avs_readdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and mask registers
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_interrupt_control <= `PPIC_CTRL_RESET;
      port1_pin_irq_mask     <= `PPIC_MASK_RESET;
    end else if (wr) begin
      if (i_avs_address == `PPIC_OFS_CTRL) begin
        port_interrupt_control <= i_avs_writedata & `PPIC_CTRL_WMASK;
      end
      if (i_avs_address == `PPIC_OFS_P1_MASK) begin
        port1_pin_irq_mask <= i_avs_writedata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pending flags, write 0 clears, set wins
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port0_pending_flags <= `PPIC_FLAG_RESET;
      port1_pending_flags <= `PPIC_FLAG_RESET;
      port2_pending_flags <= 5'b00000;
    end else begin
      port0_pending_flags <= (wr && i_avs_address == `PPIC_OFS_P0_FLAGS) ?
        ((port0_pending_flags & i_avs_writedata) | hit0) :
        (port0_pending_flags | hit0);
      // Port 1 flags clear on 0
      port1_pending_flags <= (wr && i_avs_address == `PPIC_OFS_P1_FLAGS) ?
        ((port1_pending_flags & i_avs_writedata) | hit1) :
        (port1_pending_flags | hit1);
      port2_pending_flags <= (wr && i_avs_address == `PPIC_OFS_P2_FLAGS) ?
        ((port2_pending_flags & i_avs_writedata[4:0]) | hit2) :
        (port2_pending_flags | hit2);
    end
  end

  // ----------------------------------------------------------------
  // Request outputs
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port0_irq <= 1'b0;
      o_port1_irq <= 1'b0;
      o_port2_irq <= 1'b0;
    end else begin
      o_port0_irq <= |port0_pending_flags;
      o_port1_irq <= |port1_pending_flags;
      o_port2_irq <= |port2_pending_flags;
    end
  end

endmodule

//--- ppic_defs.vh
// Constants for the port pin interrupt control block.
// Assumes a 25 MHz system clock and an Avalon-MM register bus.
`ifndef PPIC_DEFS_VH
`define PPIC_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PPIC_ADDR_W         8
`define PPIC_OFS_P0_FLAGS   8'h88
`define PPIC_OFS_P1_FLAGS   8'h8A
`define PPIC_OFS_P2_FLAGS   8'h8B
`define PPIC_OFS_CTRL       8'h8C
`define PPIC_OFS_P1_MASK    8'h90

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PPIC_CTRL_SPARE     6
`define PPIC_CTRL_P2_EN     5
`define PPIC_CTRL_P0H_EN    4
`define PPIC_CTRL_P0L_EN    3
`define PPIC_CTRL_P2_EDGE   2
`define PPIC_CTRL_P1_EDGE   1
`define PPIC_CTRL_P0_EDGE   0
`define PPIC_CTRL_WMASK     8'h7F
`define PPIC_CTRL_RESET     8'h00
`define PPIC_MASK_RESET     8'h00
`define PPIC_FLAG_RESET     8'h00
`define PPIC_P2_WMASK       8'h1F

`endif

//--- ppic_edge.v
// Edge detector for one group of port pins.
// Assumes pin inputs already synchronous to i_clk.
module ppic_edge #(
  parameter WIDTH = 8
) (
  input  wire             i_clk,    // System clock
  input  wire             i_rst_n,  // Async reset, active low
  input  wire [WIDTH-1:0] i_pins,   // Pin levels
  input  wire             i_fall,   // 1 selects falling edge
  output wire [WIDTH-1:0] o_edge    // One-cycle edge pulses
);

  reg [WIDTH-1:0] prev;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev <= {WIDTH{1'b0}};
    end else begin
      prev <= i_pins;
    end
  end

  assign o_edge = i_fall ? (prev & ~i_pins) : (~prev & i_pins);

endmodule

//--- ppic_properties.sv
// Checker for the port pin interrupt control ports.
// Assumes binding to ppic_top; control and mask are shadowed here.
`include "ppic_defs.vh"
module ppic_properties (
  input wire logic       i_clk,             // Clock
  input wire logic       i_rst_n,           // Reset
  input wire logic [7:0] i_avs_address,     // Address
  input wire logic       i_avs_read,        // Read
  input wire logic       i_avs_write,       // Write
  input wire logic [7:0] i_avs_writedata,   // Data
  input wire logic       o_avs_waitrequest, // Stall
  input wire logic [7:0] i_port0,           // Port 0
  input wire logic [7:0] i_port1,           // Port 1
  input wire logic [4:0] i_port2,           // Port 2
  input wire logic       o_port0_irq,       // Request 0
  input wire logic       o_port1_irq,       // Request 1
  input wire logic       o_port2_irq        // Request 2
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cfg;
  logic [7:0] msk;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= 8'h00;
      msk <= 8'h00;
    end else if (i_avs_write && !o_avs_waitrequest) begin
      if (i_avs_address == `PPIC_OFS_CTRL) cfg <= i_avs_writedata;
      if (i_avs_address == `PPIC_OFS_P1_MASK) msk <= i_avs_writedata;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_ans;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  a_bus_answer: assert property (
    s_req |-> ##[1:2] s_ans) else $error("no bus answer");
  a_p1_rise_req: assert property (
    !cfg[1] && |(~$past(i_port1) & i_port1 & msk) |-> ##[1:3] o_port1_irq)
    else $error("port 1 request missing");
  a_p0_low_req: assert property (
    !cfg[0] && cfg[3] && |(~$past(i_port0[3:0]) & i_port0[3:0])
    |-> ##[1:3] o_port0_irq) else $error("port 0 low request missing");
  a_p0_high_req: assert property (
    !cfg[0] && cfg[4] && |(~$past(i_port0[7:4]) & i_port0[7:4])
    |-> ##[1:3] o_port0_irq) else $error("port 0 high request missing");
  a_p2_edge_req: assert property (
    cfg[5] && |(cfg[2] ? $past(i_port2) & ~i_port2 : ~$past(i_port2) & i_port2)
    |-> ##[1:3] o_port2_irq) else $error("port 2 request missing");
  a_p2_group_gate: assert property (
    $rose(o_port2_irq) |-> ($past(cfg, 2) & 8'h20) != 8'h00)
    else $error("port 2 request while disabled");
  a_p0_group_gate: assert property (
    $rose(o_port0_irq) |-> ($past(cfg, 2) & 8'h18) != 8'h00)
    else $error("port 0 request while disabled");
  a_p1_mask_gate: assert property (
    $rose(o_port1_irq) |-> $past(msk, 2) != 8'h00)
    else $error("port 1 request while masked");
endmodule
bind ppic_top ppic_properties i_ppic_properties (.*);

//--- ppic_pin_model.sv
// External signal source for the port pins and the resume event.
// Assumes levels requested by the bench; drives them at clock edges.
module ppic_pin_model (
  input  wire logic       i_clk,   // Clock
  input  wire logic [7:0] i_lvl0,  // Port 0 level
  input  wire logic [7:0] i_lvl1,  // Port 1 level
  input  wire logic [4:0] i_lvl2,  // Port 2 level
  input  wire logic       i_lvl3,  // Resume level
  output logic      [7:0] o_port0, // Port 0 pins
  output logic      [7:0] o_port1, // Port 1 pins
  output logic      [4:0] o_port2, // Port 2 pins
  output logic            o_resume // Resume event
);
  timeunit 1ns;
  timeprecision 1ns;
  // resume follows its level at each clock edge, like the port pins
  always @(posedge i_clk) begin
    o_port0 <= i_lvl0;
    o_port1 <= i_lvl1;
    o_port2 <= i_lvl2;
    o_resume <= i_lvl3;
  end
endmodule

//--- port_pin_interrupt_control_tb_top.sv
// Testbench for the port pin interrupt control block.
// Assumes a 25 MHz clock and the pin model as signal source.
module port_pin_interrupt_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [7:0] i_avs_address = 8'h00, i_avs_writedata = 8'h00, o_avs_readdata;
  logic [7:0] lvl0 = 8'h00, lvl1 = 8'h00, i_port0, i_port1;
  logic [4:0] lvl2 = 5'h00, i_port2;
  logic lvl3 = 1'b0, i_resume, o_avs_waitrequest;
  logic o_port0_irq, o_port1_irq, o_port2_irq;
  int errors = 0, tests_run = 0;
  ppic_top i_ppic_top (.*);
  ppic_pin_model i_ppic_pin_model (.i_clk(i_clk), .i_lvl0(lvl0),
    .i_lvl1(lvl1), .i_lvl2(lvl2), .i_lvl3(lvl3), .o_port0(i_port0),
    .o_port1(i_port1), .o_port2(i_port2), .o_resume(i_resume));
  initial forever #20 i_clk = ~i_clk;
  task automatic print_verdict;
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    @(posedge i_clk);
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk($sformatf("reg_%h", a), e, q);
  endtask
  // Set control, move pins, check request, flags and clearing
  task automatic pe(input logic [7:0] c, input int p, input logic [7:0] v,
                    a, e);
    logic r;
    wr(8'h8C, c);
    case (p)
      0: lvl0 <= v;
      1: lvl1 <= v;
      2: lvl2 <= v[4:0];
      default: lvl3 <= v[0];
    endcase
    repeat (6) @(posedge i_clk);
    r = a == 8'h88 ? o_port0_irq : a == 8'h8A ? o_port1_irq : o_port2_irq;
    chk("irq", {7'h00, e != 8'h00}, {7'h00, r});
    rd(a, e);
    wr(a, 8'h00);
    rd(a, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(8'h8C, 8'h00);
    rd(8'h90, 8'h00);
    wr(8'h8C, 8'hFF);
    rd(8'h8C, 8'h7F);
    rd(8'h00, 8'h00);
    pe(8'h08, 0, 8'hFF, 8'h88, 8'h0F);
    pe(8'h10, 0, 8'h00, 8'h88, 8'h00);
    pe(8'h10, 0, 8'hFF, 8'h88, 8'hF0);
    pe(8'h19, 0, 8'h00, 8'h88, 8'hFF);
    pe(8'h10, 3, 8'h01, 8'h88, 8'h80);
    wr(8'h90, 8'h0F);
    pe(8'h00, 1, 8'hFF, 8'h8A, 8'h0F);
    pe(8'h02, 1, 8'h00, 8'h8A, 8'h0F);
    pe(8'h00, 2, 8'h1F, 8'h8B, 8'h00);
    pe(8'h24, 2, 8'h00, 8'h8B, 8'h1F);
    pe(8'h20, 2, 8'h1F, 8'h8B, 8'h1F);
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    print_verdict();
  end
endmodule
